// ### logic/fap_pkg.sv
package fap_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte addresses on the Wishbone slave
	localparam logic [3:0] FAP_ADDR_CTRL1 = 4'h0;
	localparam logic [3:0] FAP_ADDR_CTRL2 = 4'h4;
	localparam logic [3:0] FAP_ADDR_REQ = 4'h8;
	localparam logic [3:0] FAP_ADDR_STAT = 4'hC;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int FAP_R1_CODE_LSB = 0;
	localparam int FAP_LOC_CODE_LSB = 3;
	localparam int FAP_R2_CODE_LO_LSB = 6;
	localparam int FAP_R2_CODE_MSB_BIT = 0;
	localparam int FAP_R1_EN_BIT = 5;
	localparam int FAP_LOC_EN_BIT = 6;
	localparam int FAP_R2_EN_BIT = 7;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] FAP_CTRL1_RST = 8'h00;
	localparam logic [7:0] FAP_CTRL2_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Timing: base waits in monitoring cycles for code 000
	localparam int FAP_CNT_W = 11;
	localparam logic [10:0] FAP_DEC_BASE = 11'h004;
	localparam logic [10:0] FAP_INC_BASE = 11'h008;
	localparam logic [3:0] FAP_NUM_CH = 4'h3;

	typedef enum logic [2:0] {
		FAP_IDLE = 3'b001,
		FAP_ACK = 3'b010,
		FAP_DONE = 3'b100
	} fap_bus_st_t;

endpackage : fap_pkg

// ### logic/fap_channel.sv
`timescale 1ns/10ps
module fap_channel (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Monitoring tick and setup
	input wire logic mon_tick,
	input wire logic enable,
	input wire logic [2:0] code,
	// Adjustment requests and grants
	input wire logic dec_req,
	input wire logic inc_req,
	output logic dec_ok,
	output logic inc_ok,
	output logic [fap_pkg::FAP_CNT_W-1:0] elapsed
);
	import fap_pkg::*;

	logic [FAP_CNT_W-1:0] cnt_ff;
	logic [FAP_CNT_W-1:0] dec_wait;
	logic [FAP_CNT_W-1:0] inc_wait;

	assign dec_wait = FAP_DEC_BASE << code;
	assign inc_wait = FAP_INC_BASE << code;

	assign dec_ok = enable && (cnt_ff >= dec_wait);
	assign inc_ok = enable && (cnt_ff >= inc_wait);
	assign elapsed = cnt_ff;

	////////////////////////////////////////////////////////////////////////
	// Cycle counter restart
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (!enable) begin
			cnt_ff <= '0;
		end else if ((dec_req && dec_ok) || (inc_req && inc_ok)) begin
			cnt_ff <= '0;
		end else if (mon_tick && (cnt_ff != {FAP_CNT_W{1'b1}})) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

endmodule : fap_channel

// ### logic/fap_top.sv
`timescale 1ns/10ps
// Contract
// - Bits 2:0 of the control register hold the remote-one wait code.
// - Codes 0 to 7 give decrease waits of 4 doubling up to 512 cycles.
// - Increase waits are twice the decrease wait, 8 up to 1024 cycles.
// - Bits 5:3 hold the local wait code with the same encoding.
// - Pacing applies only to channels whose dynamic enable bit is set.
// - Remote-two code is bit 0 of control one plus bits 7:6 here.
module fap_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Monitoring tick
	input wire logic mon_tick,
	// Adjustment requests per channel: bit0 remote one, bit1 local, bit2 two
	input wire logic [2:0] dec_req,
	input wire logic [2:0] inc_req,
	// Grants, one-cycle pulses
	output logic [2:0] dec_grant,
	output logic [2:0] inc_grant
);
	import fap_pkg::*;

	fap_bus_st_t st_ff;
	fap_bus_st_t nxt_st;
	logic [7:0] ctrl1_ff;
	logic [7:0] ctrl2_ff;
	logic [31:0] rdat_ff;
	logic [31:0] nxt_rdat;
	logic ack_ff;
	logic [2:0] dec_grant_ff;
	logic [2:0] inc_grant_ff;
	logic [2:0] dec_ok;
	logic [2:0] inc_ok;
	logic [2:0] ch_en;
	logic [2:0] ch_code [3];
	logic [FAP_CNT_W-1:0] ch_elapsed [3];
	logic req_take;
	logic [2:0] dec_eff;
	logic [2:0] inc_eff;
	logic sel_ctrl1;
	logic sel_ctrl2;
	logic wr_take;

	////////////////////////////////////////////////////////////////////////
	// Address compare
	function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
		hit = (a == b);
	endfunction : hit

	// Grant-ready flags packed into the request status word
	function automatic logic [31:0] pack_ok(input logic [2:0] d,
		input logic [2:0] u);
		pack_ok = {24'h000000, 2'h0, u, d};
	endfunction : pack_ok

	// Elapsed counts packed into the count status word
	function automatic logic [31:0] pack_count(
		input logic [FAP_CNT_W-1:0] r1,
		input logic [FAP_CNT_W-1:0] loc,
		input logic [FAP_CNT_W-1:0] r2);
		pack_count = {loc[9:0], r1, r2};
	endfunction : pack_count

	////////////////////////////////////////////////////////////////////////
	// Channel setup from control registers
	// Remote one code
	assign ch_code[0] = ctrl2_ff[FAP_R1_CODE_LSB +: 3];
	assign ch_code[1] = ctrl2_ff[FAP_LOC_CODE_LSB +: 3];
	assign ch_code[2] = {ctrl1_ff[FAP_R2_CODE_MSB_BIT],
		ctrl2_ff[FAP_R2_CODE_LO_LSB +: 2]};
	assign ch_en = {ctrl1_ff[FAP_R2_EN_BIT], ctrl1_ff[FAP_LOC_EN_BIT],
		ctrl1_ff[FAP_R1_EN_BIT]};

	// Decrease takes priority when both directions ask at once
	assign dec_eff = dec_req;
	assign inc_eff = inc_req & ~dec_req;

	////////////////////////////////////////////////////////////////////////
	// Remote one pacing channel
	fap_channel u_fap_channel_r1 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.mon_tick(mon_tick),
		.enable(ch_en[0]),
		.code(ch_code[0]),
		.dec_req(dec_eff[0]),
		.inc_req(inc_eff[0]),
		.dec_ok(dec_ok[0]),
		.inc_ok(inc_ok[0]),
		.elapsed(ch_elapsed[0])
	);

	////////////////////////////////////////////////////////////////////////
	// Local pacing channel
	fap_channel u_fap_channel_loc (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.mon_tick(mon_tick),
		.enable(ch_en[1]),
		.code(ch_code[1]),
		.dec_req(dec_eff[1]),
		.inc_req(inc_eff[1]),
		.dec_ok(dec_ok[1]),
		.inc_ok(inc_ok[1]),
		.elapsed(ch_elapsed[1])
	);

	////////////////////////////////////////////////////////////////////////
	// Remote two pacing channel
	fap_channel u_fap_channel_r2 (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.mon_tick(mon_tick),
		.enable(ch_en[2]),
		.code(ch_code[2]),
		.dec_req(dec_eff[2]),
		.inc_req(inc_eff[2]),
		.dec_ok(dec_ok[2]),
		.inc_ok(inc_ok[2]),
		.elapsed(ch_elapsed[2])
	);

	////////////////////////////////////////////////////////////////////////
	// Decrease and increase grant pulses
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_grant_ff <= '0;
		end else begin
			dec_grant_ff <= dec_eff & dec_ok;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			inc_grant_ff <= '0;
		end else begin
			inc_grant_ff <= inc_eff & inc_ok;
		end
	end

	assign dec_grant = dec_grant_ff;
	assign inc_grant = inc_grant_ff;

	////////////////////////////////////////////////////////////////////////
	// Wishbone handshake: ack one cycle after request, then drop
	assign req_take = wb_cyc_i && wb_stb_i;

	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			FAP_IDLE: begin
				if (req_take) begin
					nxt_st = FAP_ACK;
				end
			end
			FAP_ACK: begin
				nxt_st = FAP_DONE;
			end
			FAP_DONE: begin
				if (!req_take) begin
					nxt_st = FAP_IDLE;
				end
			end
			default: begin
				nxt_st = FAP_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= FAP_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (st_ff == FAP_IDLE) && req_take;
		end
	end

	assign wb_ack_o = ack_ff;

	////////////////////////////////////////////////////////////////////////
	// Register writes take effect on the edge that samples ack
	assign sel_ctrl1 = hit(wb_adr_i, FAP_ADDR_CTRL1);
	assign sel_ctrl2 = hit(wb_adr_i, FAP_ADDR_CTRL2);
	assign wr_take = ack_ff && req_take && wb_we_i && wb_sel_i[0];

	// Control one: enables and remote-two code MSB
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_ff <= FAP_CTRL1_RST;
		end else if (wr_take && sel_ctrl1) begin
			// Bit 1 reserved, reads zero
			ctrl1_ff <= wb_dat_i[7:0] & 8'hFD;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl2_ff <= FAP_CTRL2_RST;
		end else if (wr_take && sel_ctrl2) begin
			ctrl2_ff <= wb_dat_i[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux
	always_comb begin
		nxt_rdat = 32'h00000000;
		case (wb_adr_i)
			FAP_ADDR_CTRL1: begin
				nxt_rdat = {24'h000000, ctrl1_ff};
			end
			FAP_ADDR_CTRL2: begin
				nxt_rdat = {24'h000000, ctrl2_ff};
			end
			FAP_ADDR_REQ: begin
				nxt_rdat = pack_ok(dec_ok, inc_ok);
			end
			FAP_ADDR_STAT: begin
				nxt_rdat = pack_count(ch_elapsed[0], ch_elapsed[1],
					ch_elapsed[2]);
			end
			default: begin
				nxt_rdat = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdat_ff <= 32'h00000000;
		end else if ((st_ff == FAP_IDLE) && req_take) begin
			rdat_ff <= nxt_rdat;
		end
	end

	assign wb_dat_o = rdat_ff;

endmodule : fap_top

// ### tb/fap_top_assertions.sv
`timescale 1ns/10ps
module fap_top_assertions (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	// Pacing
	input wire logic mon_tick,
	input wire logic [2:0] dec_req,
	input wire logic [2:0] inc_req,
	input wire logic [2:0] dec_grant,
	input wire logic [2:0] inc_grant
);
	logic [11:0] tk_ff;
	logic wr_ff;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Ticks since the last remote-one grant
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			tk_ff <= 12'h000;
		else if (dec_grant[0] | inc_grant[0])
			tk_ff <= {11'h000, mon_tick};
		else
			tk_ff <= tk_ff + {11'h000, mon_tick};
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			wr_ff <= 1'h0;
		else if (wb_ack_o & wb_we_i)
			wr_ff <= 1'h1;
	end
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	chk_ack_next: assert property (s_take |=> wb_ack_o)
		else $error("ack late");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_dec_cause: assert property ((dec_grant & ~$past(dec_req)) == 3'h0)
		else $error("dec grant without request");
	chk_inc_yield: assert property
		((inc_grant & ($past(dec_req) | ~$past(inc_req))) == 3'h0)
		else $error("inc grant wrong");
	chk_grant_pulse: assert property
		(((dec_grant | inc_grant) & $past(dec_grant | inc_grant)) == 3'h0)
		else $error("grant too long");
	chk_dec_space: assert property (dec_grant[0] |-> tk_ff >= 12'h004)
		else $error("dec grant too soon");
	chk_inc_space: assert property (inc_grant[0] |-> tk_ff >= 12'h008)
		else $error("inc grant too soon");
	chk_idle_quiet: assert property (!wr_ff |-> (dec_grant | inc_grant) == 3'h0)
		else $error("grant while disabled");
endmodule : fap_top_assertions

// ### tb/fap_top_tb.sv
`timescale 1ns/10ps
module fap_top_tb;
	import fap_pkg::*;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, mon_tick = 1'h0;
	logic wb_ack_o;
	logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic [2:0] dec_req = 3'h0, inc_req = 3'h0, dec_grant, inc_grant;
	int mismatches = 0, comparisons = 0;
	always #5 ref_clk = ~ref_clk;
	fap_top u_fap_top (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mon_tick,
		.dec_req, .inc_req, .dec_grant, .inc_grant);
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask : wb
	// Grants of one channel, ticks counted between grants
	task pace(input logic [2:0] ch, input logic [2:0] c, input logic up);
		int n, g;
		wb(1'h1, FAP_ADDR_CTRL2, {24'h0, c[1:0], c, c});
		wb(1'h0, FAP_ADDR_CTRL2, 32'h0);
		chk(rd, {24'h0, c[1:0], c, c});
		wb(1'h1, FAP_ADDR_CTRL1, {24'h0, ch, 4'h0, c[2]});
		dec_req <= up ? ~ch : 3'h7;
		inc_req <= 3'h7;
		n = 0;
		g = 0;
		for (int k = 0; k < 8000 && g < 3; k++) begin
			@(posedge ref_clk);
			mon_tick <= ~mon_tick;
			if ((up ? inc_grant : dec_grant) !== 3'h0) begin
				g++;
				chk({29'h0, up ? inc_grant : dec_grant}, {29'h0, ch});
				if (g > 1) chk(n, (4 << c) << up);
				n = mon_tick;
			end else
				n += mon_tick;
		end
		chk(g, 3);
		dec_req <= 3'h0;
		inc_req <= 3'h0;
		mon_tick <= 1'h0;
		wb(1'h1, FAP_ADDR_CTRL1, 32'h0);
	endtask : pace
	// Counters and ready flags seen through the status words
	task regs_check;
		wb(1'h1, FAP_ADDR_CTRL2, 32'h00000000);
		wb(1'h1, FAP_ADDR_CTRL1, 32'h00000020);
		repeat (16) begin
			@(posedge ref_clk);
			mon_tick <= ~mon_tick;
		end
		wb(1'h0, FAP_ADDR_REQ, 32'h00000000);
		chk(rd, 32'h00000009);
		wb(1'h0, FAP_ADDR_STAT, 32'h00000000);
		chk(rd, 32'h00004000);
		wb(1'h1, FAP_ADDR_CTRL1, 32'h00000000);
		wb(1'h0, FAP_ADDR_STAT, 32'h00000000);
		chk(rd, 32'h00000000);
	endtask : regs_check
	task finish_test;
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'h1;
		wb(1'h0, FAP_ADDR_CTRL2, 32'h0);
		chk(rd, {24'h0, FAP_CTRL2_RST});
		wb(1'h1, FAP_ADDR_CTRL1, 32'hFF);
		wb(1'h0, FAP_ADDR_CTRL1, 32'h0);
		chk(rd, 32'hFD);
		regs_check;
		for (int c = 0; c < 8; c++) begin
			pace(3'h1 << (c % 3), 3'(c), 1'h0);
			pace(3'h1 << (c % 3), 3'(c), 1'h1);
		end
		finish_test;
	end
	initial begin
		#1000000;
		mismatches++;
		finish_test;
	end
endmodule : fap_top_tb
bind fap_top fap_top_assertions u_fap_top_assertions (.ref_clk, .rst_n,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .mon_tick, .dec_req,
	.inc_req, .dec_grant, .inc_grant);
